// File: hdl/psa_top.sv
// Eight-slice PWM generator with a classic Wishbone register slave.
`timescale 1ns/100ps
`include "psa_consts.svh"
// How it works
// - Running slice holds new compare values in shadow until wrap or zero turn.
// - Stopped slice copies compare and wrap writes into use one cycle later.
// - Running slice holds new wrap limit in shadow until wrap or zero turn.
// - Output high while counter below compare, low from reaching it.
// - Wrap limit is highest count; normal mode then returns to zero.
// - Phase-correct counter turns down at limit, back up at zero.
// - Divider takes 8-bit integer and 4-bit fraction.
// - Counter steps at clock over ratio, gated by divider mode.
// - Retard skips exactly one count; busy bit shows until done.
// - Software may write any counter value directly.
// - Per-slice enable; one mask write sets all eight enables.
// - Separate invert bits for A and B outputs.
// - Per-slice interrupt enables with mask set, clear and write.
// - Pin maps to slice and channel; pins 16 apart share one.
// - Channel select zero picks A compare, one picks B.
// - Mode codes: free 0, B high 1, B rise 2, B fall 3.
// - Normal mode counts up to limit then zero on next step.
// - Default: free running, no phase correction, limit FFFF, no invert.
module psa_top (
    input  wire logic                               core_clk,
    input  wire logic                               rst,
    input  wire logic                               wb_cyc_i,
    input  wire logic                               wb_stb_i,
    input  wire logic                               wb_we_i,
    input  wire logic [7:0]                         wb_adr_i,
    input  wire logic [31:0]                        wb_dat_i,
    input  wire logic [3:0]                         wb_sel_i,
    output logic      [31:0]                        wb_dat_o,
    output logic                                    wb_ack_o,
    input  wire logic [`PSA_SLICES-1:0]             pwm_b_in,
    output psa_pkg::psa_chan_type [`PSA_SLICES-1:0] slice_out,
    output logic      [`PSA_PINS-1:0]               pwm_pin,
    output logic      [`PSA_SLICES-1:0]             irq_enable
);
    import psa_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic reg_hit(input logic [7:0] adr, input int sl, input logic [7:0] off);
        reg_hit = (adr == 8'(sl * `PSA_STRIDE + off));
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int k = 0; k < 4; k++) begin
            merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
        end
    endfunction

    function automatic logic [2:0] pin_slice(input logic [4:0] pin);
        pin_slice = pin[3:1];
    endfunction

    function automatic logic pin_chan(input logic [4:0] pin);
        pin_chan = pin[0];
    endfunction

    // ==========================================================
    // Bus slave
    logic        ack_q;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic        wr;

    assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rd_q  <= 32'h0000_0000;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            rd_q  <= rd_d;
        end
    end

    // ==========================================================
    // Slice state
    psa_csr_type cfg_q [`PSA_SLICES];
    logic [11:0] div_q [`PSA_SLICES];
    logic [12:0] acc_q [`PSA_SLICES];
    logic [15:0] ctr_q [`PSA_SLICES];
    logic [15:0] cca_sh [`PSA_SLICES];
    logic [15:0] ccb_sh [`PSA_SLICES];
    logic [15:0] cca_q [`PSA_SLICES];
    logic [15:0] ccb_q [`PSA_SLICES];
    logic [15:0] top_sh [`PSA_SLICES];
    logic [15:0] top_q [`PSA_SLICES];
    logic [`PSA_SLICES-1:0] en_q;
    logic [`PSA_SLICES-1:0] csr_w;
    logic [`PSA_SLICES-1:0] inte_q;
    logic        en_w;
    logic        lsel_w;
    logic        plvl_w;
    logic [2:0]  lsel_sl;
    logic        lsel_ch;
    logic [4:0]  plvl_pin;
    psa_csr_type wcsr;

    assign en_w     = wr && (wb_adr_i == `PSA_OFF_EN);
    assign lsel_w   = wr && (wb_adr_i == `PSA_OFF_LSEL);
    assign plvl_w   = wr && (wb_adr_i == `PSA_OFF_PLVL);
    assign lsel_sl  = wb_dat_i[`PSA_SEL_SL +: 3];
    assign lsel_ch  = wb_dat_i[`PSA_SEL_CH];
    assign plvl_pin = wb_dat_i[`PSA_PIN_LSB +: 5];
    assign wcsr     = psa_csr_type'(wb_dat_i[7:0]);

    // Writing the mask register sets every enable in one cycle, so slices start aligned.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_q <= '0;
        end else begin
            for (int i = 0; i < `PSA_SLICES; i++) begin
                if (en_w && wb_sel_i[0]) begin
                    en_q[i] <= wb_dat_i[i];
                end else if (csr_w[i] && wb_sel_i[0]) begin
                    en_q[i] <= wcsr.en;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            inte_q <= '0;
        end else if (wr && wb_sel_i[0]) begin
            if (wb_adr_i == `PSA_OFF_INTE) begin
                inte_q <= wb_dat_i[7:0];
            end else if (wb_adr_i == `PSA_OFF_INTS) begin
                inte_q <= inte_q | wb_dat_i[7:0];
            end else if (wb_adr_i == `PSA_OFF_INTC) begin
                inte_q <= inte_q & ~wb_dat_i[7:0];
            end
        end
    end
    assign irq_enable = inte_q;

    // ==========================================================
    // Per-slice logic
    for (genvar i = 0; i < `PSA_SLICES; i++) begin : g_slice
        logic        div_w;
        logic        ctr_w;
        logic        cc_w;
        logic        top_w;
        logic        bprev_q;
        logic        down_q;
        logic        ev;
        logic        tick;
        logic        skip;
        logic        at_top;
        logic        at_zero;
        logic        reload;
        logic        lva_w;
        logic        lvb_w;
        logic [12:0] acc_add;
        logic [31:0] cc_m;
        logic [31:0] top_m;
        logic [31:0] div_m;
        logic [31:0] ctr_m;
        psa_chan_type out_q;

        assign csr_w[i] = wr && reg_hit(wb_adr_i, i, `PSA_OFF_CSR);
        assign div_w    = wr && reg_hit(wb_adr_i, i, `PSA_OFF_DIV);
        assign ctr_w    = wr && reg_hit(wb_adr_i, i, `PSA_OFF_CTR);
        assign cc_w     = wr && reg_hit(wb_adr_i, i, `PSA_OFF_CC);
        assign top_w    = wr && reg_hit(wb_adr_i, i, `PSA_OFF_TOP);
        assign lva_w    = (lsel_w && lsel_sl == 3'(i) && !lsel_ch)
                       || (plvl_w && pin_slice(plvl_pin) == 3'(i) && !pin_chan(plvl_pin));
        assign lvb_w    = (lsel_w && lsel_sl == 3'(i) && lsel_ch)
                       || (plvl_w && pin_slice(plvl_pin) == 3'(i) && pin_chan(plvl_pin));
        assign cc_m     = merge({ccb_sh[i], cca_sh[i]}, wb_dat_i, wb_sel_i);
        assign top_m    = merge({16'h0000, top_sh[i]}, wb_dat_i, wb_sel_i);
        assign div_m    = merge({20'h00000, div_q[i]}, wb_dat_i, wb_sel_i);
        assign ctr_m    = merge({16'h0000, ctr_q[i]}, wb_dat_i, wb_sel_i);

        always_ff @(posedge core_clk) begin
            if (rst) begin
                cfg_q[i] <= psa_csr_type'(`PSA_CFG_RST);
            end else begin
                if (csr_w[i] && wb_sel_i[0]) begin
                    cfg_q[i].phase <= wcsr.phase;
                    cfg_q[i].inv_a <= wcsr.inv_a;
                    cfg_q[i].inv_b <= wcsr.inv_b;
                    cfg_q[i].mode  <= wcsr.mode;
                end
                // A request arriving as the skip lands stays pending.
                cfg_q[i].retard <= (csr_w[i] && wb_sel_i[0] && wcsr.retard && en_q[i])
                                || (cfg_q[i].retard && !skip);
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                div_q[i] <= `PSA_DIV_RST;
            end else if (div_w) begin
                div_q[i] <= div_m[11:0];
            end
        end

        // Divider gating by the B input.
        always_ff @(posedge core_clk) begin
            if (rst) begin
                bprev_q <= 1'b0;
            end else begin
                bprev_q <= pwm_b_in[i];
            end
        end

        always_comb begin
            unique case (cfg_q[i].mode)
                PSA_FREE:   ev = 1'b1;
                PSA_B_HIGH: ev = pwm_b_in[i];
                PSA_B_RISE: ev = pwm_b_in[i] && !bprev_q;
                PSA_B_FALL: ev = !pwm_b_in[i] && bprev_q;
            endcase
        end

        // The accumulator counts in sixteenths; the remainder carries over so no time is lost.
        assign acc_add = acc_q[i] + `PSA_ONE;
        assign tick    = en_q[i] && ev && (acc_add >= {1'b0, div_q[i]});
        assign skip    = tick && cfg_q[i].retard;

        always_ff @(posedge core_clk) begin
            if (rst || !en_q[i]) begin
                acc_q[i] <= 13'h0000;
            end else if (ev) begin
                acc_q[i] <= tick ? 13'(acc_add - {1'b0, div_q[i]}) : acc_add;
            end
        end

        assign at_top  = ctr_q[i] >= top_q[i];
        assign at_zero = ctr_q[i] == 16'h0000;
        assign reload  = tick && (cfg_q[i].phase ? (down_q && at_zero) : at_top);

        always_ff @(posedge core_clk) begin
            if (rst) begin
                ctr_q[i] <= 16'h0000;
                down_q   <= 1'b0;
            end else if (ctr_w) begin
                ctr_q[i] <= ctr_m[15:0];
            end else if (!cfg_q[i].phase) begin
                down_q <= 1'b0;
                if (tick && !skip) begin
                    ctr_q[i] <= at_top ? 16'h0000 : 16'(ctr_q[i] + 16'h0001);
                end
            end else if (tick && !skip) begin
                // Both turning points hold their count one extra tick, so the period is twice the normal one.
                if (!down_q && at_top) begin
                    down_q   <= 1'b1;
                end else if (down_q && at_zero) begin
                    down_q   <= 1'b0;
                end else begin
                    ctr_q[i] <= down_q ? 16'(ctr_q[i] - 16'h0001) : 16'(ctr_q[i] + 16'h0001);
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                cca_sh[i] <= 16'h0000;
                ccb_sh[i] <= 16'h0000;
                top_sh[i] <= `PSA_TOP_RST;
            end else begin
                if (cc_w) begin
                    cca_sh[i] <= cc_m[15:0];
                    ccb_sh[i] <= cc_m[31:16];
                end else begin
                    if (lva_w) cca_sh[i] <= wb_dat_i[15:0];
                    if (lvb_w) ccb_sh[i] <= wb_dat_i[15:0];
                end
                if (top_w) top_sh[i] <= top_m[15:0];
            end
        end

        // Stopped slices track the shadow each cycle, so writes land one cycle later.
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cca_q[i] <= 16'h0000;
                ccb_q[i] <= 16'h0000;
                top_q[i] <= `PSA_TOP_RST;
            end else if (!en_q[i] || reload) begin
                cca_q[i] <= cca_sh[i];
                ccb_q[i] <= ccb_sh[i];
                top_q[i] <= top_sh[i];
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                out_q <= '0;
            end else begin
                out_q.a <= (ctr_q[i] < cca_q[i]) ^ cfg_q[i].inv_a;
                out_q.b <= (ctr_q[i] < ccb_q[i]) ^ cfg_q[i].inv_b;
            end
        end
        assign slice_out[i] = out_q;
    end

    // ==========================================================
    // Pin map
    for (genvar p = 0; p < `PSA_PINS; p++) begin : g_pin
        assign pwm_pin[p] = pin_chan(5'(p)) ? slice_out[pin_slice(5'(p))].b
                                            : slice_out[pin_slice(5'(p))].a;
    end

    // ==========================================================
    // Read mux
    always_comb begin
        rd_d = 32'h0000_0000;
        if (wb_adr_i == `PSA_OFF_EN) rd_d = {24'h000000, en_q};
        if (wb_adr_i == `PSA_OFF_INTE) rd_d = {24'h000000, inte_q};
        for (int i = 0; i < `PSA_SLICES; i++) begin
            if (reg_hit(wb_adr_i, i, `PSA_OFF_CSR)) begin
                rd_d = {24'h000000, cfg_q[i].retard, 1'b0, cfg_q[i].mode,
                        cfg_q[i].inv_b, cfg_q[i].inv_a, cfg_q[i].phase, en_q[i]};
            end
            if (reg_hit(wb_adr_i, i, `PSA_OFF_DIV)) rd_d = {20'h00000, div_q[i]};
            if (reg_hit(wb_adr_i, i, `PSA_OFF_CTR)) rd_d = {16'h0000, ctr_q[i]};
            if (reg_hit(wb_adr_i, i, `PSA_OFF_CC)) rd_d = {ccb_sh[i], cca_sh[i]};
            if (reg_hit(wb_adr_i, i, `PSA_OFF_TOP)) rd_d = {16'h0000, top_sh[i]};
        end
    end
endmodule // psa_top

// File: shared/psa_consts.svh
// Offsets, field positions, reset values and counts of the PWM slice array.
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH
`define PSA_SLICES      8
`define PSA_PINS        30
`define PSA_STRIDE      8'h14
`define PSA_OFF_CSR     8'h00
`define PSA_OFF_DIV     8'h04
`define PSA_OFF_CTR     8'h08
`define PSA_OFF_CC      8'h0C
`define PSA_OFF_TOP     8'h10
`define PSA_OFF_EN      8'hA0
`define PSA_OFF_INTE    8'hA4
`define PSA_OFF_INTS    8'hA8
`define PSA_OFF_INTC    8'hAC
`define PSA_OFF_LSEL    8'hB0
`define PSA_OFF_PLVL    8'hB4
`define PSA_SEL_CH      16
`define PSA_SEL_SL      17
`define PSA_PIN_LSB     16
`define PSA_TOP_RST     16'hFFFF
`define PSA_DIV_RST     12'h010
`define PSA_ONE         13'h0010
`define PSA_CFG_RST     8'h00
`endif

// File: shared/psa_pkg.sv
// Types shared by the PWM slice array.
package psa_pkg;
    typedef enum logic [1:0] {
        PSA_FREE,
        PSA_B_HIGH,
        PSA_B_RISE,
        PSA_B_FALL
    } psa_mode_type;
    typedef struct packed {
        logic         retard;
        logic         spare;
        psa_mode_type mode;
        logic         inv_b;
        logic         inv_a;
        logic         phase;
        logic         en;
    } psa_csr_type;
    typedef struct packed {
        logic b;
        logic a;
    } psa_chan_type;
endpackage

// File: testbench/psa_properties.sv
// Checker of the PWM slice array bus handshake, interrupt enables and pin map.
`timescale 1ns/100ps
`include "psa_consts.svh"
module psa_checker (
    input wire logic                               core_clk,
    input wire logic                               rst,
    input wire logic                               wb_cyc_i,
    input wire logic                               wb_stb_i,
    input wire logic                               wb_we_i,
    input wire logic [7:0]                         wb_adr_i,
    input wire logic [31:0]                        wb_dat_i,
    input wire logic [3:0]                         wb_sel_i,
    input wire logic [31:0]                        wb_dat_o,
    input wire logic                               wb_ack_o,
    input wire logic [`PSA_SLICES-1:0]             pwm_b_in,
    input wire psa_pkg::psa_chan_type [`PSA_SLICES-1:0] slice_out,
    input wire logic [`PSA_PINS-1:0]               pwm_pin,
    input wire logic [`PSA_SLICES-1:0]             irq_enable
);
    import psa_pkg::*;
    logic                 take;
    logic                 wr0;
    logic [`PSA_PINS-1:0] exp_pin;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr0 = take & wb_we_i & wb_sel_i[0];
    always_comb begin
        for (int p = 0; p < `PSA_PINS; p++) begin
            exp_pin[p] = slice_out[(p >> 1) & 7][p & 1];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ========================================
    // Properties
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held past one cycle");
    property p_ack_ans; take |=> wb_ack_o; endproperty
    a_ack_ans: assert property (p_ack_ans) else $error("request not answered next cycle");
    property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_pin_map; pwm_pin == exp_pin; endproperty
    a_pin_map: assert property (p_pin_map) else $error("pin not mapped to its slice channel");
    // Reset itself is the cause here, so this one is never disabled.
    property p_rst_state; disable iff (1'b0) rst |=> (slice_out == '0 && irq_enable == '0 && !wb_ack_o); endproperty
    a_rst_state: assert property (p_rst_state) else $error("outputs not cleared by reset");
    property p_ie_wr; wr0 && wb_adr_i == `PSA_OFF_INTE |=> irq_enable == $past(wb_dat_i[7:0]); endproperty
    a_ie_wr: assert property (p_ie_wr) else $error("interrupt enable write lost");
    property p_ie_set; wr0 && wb_adr_i == `PSA_OFF_INTS |=> irq_enable == ($past(irq_enable) | $past(wb_dat_i[7:0]));
    endproperty
    a_ie_set: assert property (p_ie_set) else $error("interrupt enable set mask wrong");
    property p_ie_clr; wr0 && wb_adr_i == `PSA_OFF_INTC |=> irq_enable == ($past(irq_enable) & ~$past(wb_dat_i[7:0]));
    endproperty
    a_ie_clr: assert property (p_ie_clr) else $error("interrupt enable clear mask wrong");
    property p_ie_hold; !(wr0 && wb_adr_i inside {8'hA4, 8'hA8, 8'hAC}) |=> $stable(irq_enable); endproperty
    a_ie_hold: assert property (p_ie_hold) else $error("interrupt enables changed unasked");
    property p_hi_zero; take && !wb_we_i && wb_adr_i >= 8'hA8 |=> wb_dat_o == '0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("write-only or unmapped read not zero");
endmodule // psa_checker
bind psa_top psa_checker u_chk (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pwm_b_in(pwm_b_in), .slice_out(slice_out), .pwm_pin(pwm_pin), .irq_enable(irq_enable));

// File: testbench/psa_top_tb.sv
// Self-checking testbench of the PWM slice array.
`timescale 1ns/100ps
`include "psa_consts.svh"
module psa_top_tb;
    import psa_pkg::*;
    logic core_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0] adr = '0, b_in = '0, ie;
    logic [31:0] dw = '0, dr, dat_o;
    logic [3:0] sel = 4'hF;
    psa_chan_type [7:0] so;
    logic [29:0] pin;
    int failures = 0, n_checks = 0, cyc_cnt = 0;
    psa_top DUT (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dw), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwm_b_in(b_in), .slice_out(so),
        .pwm_pin(pin), .irq_enable(ie));
    always #10 core_clk = ~core_clk;
    // The gate input toggles every cycle, so gated modes tick at half rate.
    always @(posedge core_clk) b_in <= ~b_in;
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            failures++;
            give_verdict;
        end
    end
    // ========================================
    // Shared tasks
    task give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dw <= d;
        do begin @(posedge core_clk); t++; end while (ack !== 1'b1 && t < 50);
        dr = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
        if (t >= 50) failures++;
    endtask
    function logic [7:0] ra(input int n, input logic [7:0] off);
        return 8'(n * `PSA_STRIDE + off);
    endfunction
    task wait_a(input logic v);
        int t;
        t = 0;
        while (so[0].a !== v && t < 100) begin @(posedge core_clk); t++; end
    endtask
    // Counts high cycles of both outputs and rises of A over n cycles.
    task meas(input logic [7:0] csr, input logic [11:0] dv, input int n, ea, eb, er);
        int ha, hb, nr;
        logic pa;
        wb(1, `PSA_OFF_DIV, {20'h0, dv});
        wb(1, `PSA_OFF_CSR, {24'h0, csr});
        repeat (24) @(posedge core_clk);
        ha = 0; hb = 0; nr = 0; pa = so[0].a;
        repeat (n) begin
            @(posedge core_clk);
            ha += so[0].a; hb += so[0].b; nr += (so[0].a & !pa); pa = so[0].a;
            check(pin[16], pin[0]);
        end
        if (ea >= 0) check(ha, ea);
        if (eb >= 0) check(hb, eb);
        check(nr, er);
    endtask
    // ========================================
    // Scenarios
    task t_reset;
        check(so, 0);
        check(ie, 0);
        wb(0, `PSA_OFF_CSR, 0); check(dr, 0);
        wb(0, `PSA_OFF_DIV, 0); check(dr, 32'h0000_0010);
        wb(0, `PSA_OFF_TOP, 0); check(dr, 32'h0000_FFFF);
        wb(0, `PSA_OFF_CTR, 0); check(dr, 0);
        $display("reset test done");
    endtask
    task t_pwm;
        wb(1, `PSA_OFF_TOP, 3);
        wb(1, `PSA_OFF_CC, 32'h0003_0001);
        meas(8'h01, 12'h010, 40, 10, 30, 10);
        meas(8'h03, 12'h010, 40, 10, 30, 5);
        meas(8'h0D, 12'h010, 40, 30, 10, 10);
        meas(8'h01, 12'h018, 48, -1, -1, 8);
        meas(8'h11, 12'h010, 48, 12, 36, 6);
        meas(8'h21, 12'h010, 48, 12, 36, 6);
        meas(8'h31, 12'h010, 48, 12, 36, 6);
        $display("waveform test done");
    endtask
    task t_shadow;
        wb(1, `PSA_OFF_CSR, 0);
        wb(1, `PSA_OFF_DIV, 32'h0000_0100);
        wb(1, `PSA_OFF_TOP, 3);
        wb(1, `PSA_OFF_CC, 3);
        wb(1, `PSA_OFF_CTR, 2);
        wb(1, `PSA_OFF_CSR, 1);
        repeat (2) @(posedge core_clk);
        check(so[0].a, 1);
        wb(1, `PSA_OFF_CC, 1);
        wb(1, `PSA_OFF_TOP, 5);
        check(so[0].a, 1);
        wait_a(0);
        wait_a(1);
        wait_a(0);
        repeat (56) @(posedge core_clk);
        wb(0, `PSA_OFF_CTR, 0); check(dr, 4);
        $display("shadow test done");
    endtask
    task t_retard;
        logic [31:0] v [2];
        for (int r = 0; r < 2; r++) begin
            wb(1, `PSA_OFF_CSR, 0);
            wb(1, `PSA_OFF_TOP, 32'h0000_FFFF);
            wb(1, `PSA_OFF_CTR, 0);
            wb(1, `PSA_OFF_CSR, 1);
            wb(1, `PSA_OFF_CSR, r ? 32'h81 : 32'h01);
            wb(0, `PSA_OFF_CSR, 0); check(dr[7], r);
            repeat (160) @(posedge core_clk);
            wb(0, `PSA_OFF_CTR, 0);
            v[r] = dr;
            wb(0, `PSA_OFF_CSR, 0); check(dr[7], 0);
        end
        check(v[1], v[0] - 1);
        $display("retard test done");
    endtask
    task t_regs;
        wb(1, `PSA_OFF_INTE, 32'h0F); check(ie, 8'h0F);
        wb(1, `PSA_OFF_INTS, 32'h30); check(ie, 8'h3F);
        wb(1, `PSA_OFF_INTC, 32'h05); check(ie, 8'h3A);
        wb(0, `PSA_OFF_INTE, 0); check(dr, 32'h3A);
        wb(1, 8'hC0, 32'hFFFF_FFFF);
        wb(0, 8'hC0, 0); check(dr, 0);
        wb(1, `PSA_OFF_LSEL, {12'h0, 3'd2, 1'b1, 16'h1234});
        wb(1, `PSA_OFF_PLVL, {11'h0, 5'd20, 16'h0055});
        wb(0, ra(2, `PSA_OFF_CC), 0); check(dr, 32'h1234_0055);
        wb(1, `PSA_OFF_EN, 32'h0A);
        for (int n = 0; n < 8; n++) begin
            wb(0, ra(n, `PSA_OFF_CSR), 0); check(dr[0], n == 1 || n == 3);
        end
        $display("register test done");
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        t_reset;
        t_pwm;
        t_shadow;
        t_retard;
        t_regs;
        give_verdict;
    end
endmodule // psa_top_tb
